// ==== rtl/spdcp_port.sv ====
// seven-pin digital control port: command decode, pin drive and sampling
`timescale 1ns/10ps
module spdcp_port (
  input  wire logic              clk_in,       // system clock, 100 MHz
  input  wire logic              rst_n_in,     // synchronous reset, low
  input  wire logic              ce_in,        // clock enable, freezes state
  input  wire logic              cmd_valid_in, // command offered
  input  wire spdcp_pkg::spdcp_cmd_t cmd_in,   // command word
  output logic                   cmd_ready_out,// command accepted when high
  output logic                   rsp_valid_out,// one-cycle answer pulse
  output spdcp_pkg::spdcp_rsp_t  rsp_out,      // answer word
  input  wire logic [6:0]        pin_i_in,     // pin levels, pin 1 in bit 0
  output logic      [6:0]        pin_o_out,    // pin drive levels
  output logic      [6:0]        pin_oe_n_out, // low while driving the pin
  input  wire logic              fault_in,     // instrument fault, true high
  output logic                   inhibit_out,  // inhibit asserted on pin 3
  output logic      [6:0]        trig_out,     // active-edge pulse per pin
  input  wire spdcp_pkg::spdcp_cfg_t nv_cfg_in,// stored configuration
  output logic                   nv_wr_out,    // store configuration pulse
  output spdcp_pkg::spdcp_cfg_t  nv_cfg_out    // configuration to store
);
  import spdcp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state
  spdcp_cfg_t cfg_q;       // live function and polarity
  spdcp_cfg_t cfg_d;       // next configuration
  logic       loading_q;   // stored configuration not yet taken
  logic [6:0] out_q;       // port_output_value
  logic [6:0] out_d;       // next output word
  logic [6:0] lvl_prev_q;  // previous logical levels, edge detect
  logic [6:0] pin_o_q;     // registered drive levels
  logic [6:0] pin_oe_n_q;  // registered drive enables, low = drive
  logic       inhibit_q;   // registered inhibit
  logic [6:0] trig_q;      // registered edge pulses
  logic [2:0] warm_q;      // ones shifted in after reset, arms edges
  logic       rsp_valid_q; // answer pulse
  spdcp_rsp_t rsp_q;       // answer word
  spdcp_rsp_t rsp_d;       // next answer word
  logic       nv_wr_q;     // store request pulse

  ////////////////////////////////////////////////////////////////////////////
  // functions
  // pin number 1..7 to bit index, zero for illegal numbers
  function automatic logic [2:0] pin_bit(input logic [2:0] pin);
    pin_bit = (pin == 3'h0) ? 3'h0 : pin - 3'h1;
  endfunction

  // a pin number may take a function
  function automatic logic func_ok(input logic [2:0] pin, input logic [1:0] fn);
    logic ok;
    ok = (pin != 3'h0);
    if (fn == SPDCP_FN_FAULT) begin
      ok = ok && (pin == SPDCP_FAULT_PIN);
    end
    if (fn == SPDCP_FN_INHIBIT) begin
      ok = ok && (pin == SPDCP_INH_PIN);
    end
    func_ok = ok;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // input sampling
  wire logic [6:0] pin_sync;  // synchronised raw pin levels
  wire logic [6:0] lvl;       // logical levels after polarity
  wire logic [6:0] bidir_msk; // pins under general bidirectional control
  wire logic       fault_sel; // pin 1 is the fault output

  spdcp_sync #(
    .WIDTH (SPDCP_PINS)
  ) u_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .ce_in    (ce_in),
    .async_in (pin_i_in),
    .sync_out (pin_sync)
  );

  assign lvl       = pin_sync ^ cfg_q.neg;
  assign fault_sel = (cfg_q.func[SPDCP_FAULT_BIT] == SPDCP_FN_FAULT);

  ////////////////////////////////////////////////////////////////////////////
  // per-pin drive decision
  wire logic [6:0] drv_en;  // pin driven next cycle
  wire logic [6:0] drv_lvl; // level driven next cycle

  genvar g;
  generate
    for (g = 0; g < SPDCP_PINS; g++) begin : g_pin
      if (g == SPDCP_FAULT_BIT) begin : g_fault
        // pin 1 drives the fault level when so selected
        assign bidir_msk[g] = (cfg_q.func[g] == SPDCP_FN_BIDIR);
        assign drv_en[g]    = bidir_msk[g] | fault_sel;
        assign drv_lvl[g]   = (fault_sel ? fault_in : out_q[g]) ^ cfg_q.neg[g];
      end else if (g == SPDCP_RET_BIT) begin : g_ret
        // pin 2 is the fault return and leaves general use while pin 1 is the fault output
        assign bidir_msk[g] = (cfg_q.func[g] == SPDCP_FN_BIDIR) && !fault_sel;
        assign drv_en[g]    = bidir_msk[g];
        assign drv_lvl[g]   = out_q[g] ^ cfg_q.neg[g];
      end else begin : g_gen
        // input-only and inhibit pins never drive
        assign bidir_msk[g] = (cfg_q.func[g] == SPDCP_FN_BIDIR);
        assign drv_en[g]    = bidir_msk[g];
        assign drv_lvl[g]   = out_q[g] ^ cfg_q.neg[g];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // command decode
  wire logic       take    = cmd_valid_in && cmd_ready_out;  // command taken
  wire logic [2:0] idx     = pin_bit(cmd_in.pin);            // addressed bit
  wire logic       pin_ok  = (cmd_in.pin != 3'h0);           // pin 1..7
  wire logic [1:0] new_fn  = cmd_in.data[1:0];               // requested function
  wire logic       fn_ok   = func_ok(cmd_in.pin, new_fn);    // legal placement
  wire logic       cfg_chg = (cfg_d != cfg_q);               // needs storing

  assign cmd_ready_out = !loading_q;

  // next output word, configuration and answer
  always_comb begin
    out_d = out_q;
    cfg_d = cfg_q;
    rsp_d = '{err: 1'b0, data: 7'h00};
    if (take) begin
      unique case (cmd_in.op)
        SPDCP_OP_WR_OUT: begin
          // only bidirectional pins follow the written bits
          out_d = (out_q & ~bidir_msk) | (cmd_in.data & bidir_msk);
        end
        SPDCP_OP_RD_OUT: begin
          rsp_d.data = out_q;
        end
        SPDCP_OP_RD_IN: begin
          rsp_d.data = lvl;
        end
        SPDCP_OP_WR_FUNC: begin
          if (fn_ok) begin
            cfg_d.func[idx] = spdcp_func_t'(new_fn);
          end else begin
            rsp_d.err = 1'b1;
          end
        end
        SPDCP_OP_RD_FUNC: begin
          rsp_d.err  = !pin_ok;
          rsp_d.data = pin_ok ? {5'h00, cfg_q.func[idx]} : 7'h00;
        end
        SPDCP_OP_WR_POL: begin
          if (pin_ok) begin
            cfg_d.neg[idx] = cmd_in.data[0];
          end else begin
            rsp_d.err = 1'b1;
          end
        end
        SPDCP_OP_RD_POL: begin
          rsp_d.err  = !pin_ok;
          rsp_d.data = {6'h00, pin_ok & cfg_q.neg[idx]};
        end
        default: begin
          // eighth opcode is unused
          rsp_d.err = 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration, taken from storage one cycle after reset release
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cfg_q     <= SPDCP_CFG_RST;
      loading_q <= 1'b1;
      nv_wr_q   <= 1'b0;
    end else if (ce_in) begin
      loading_q <= 1'b0;
      nv_wr_q   <= !loading_q && cfg_chg;
      cfg_q     <= loading_q ? nv_cfg_in : cfg_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output word and answer
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      out_q       <= SPDCP_OUT_RST;
      rsp_valid_q <= 1'b0;
      rsp_q       <= '{err: 1'b0, data: 7'h00};
    end else if (ce_in) begin
      out_q       <= out_d;
      rsp_valid_q <= take;
      rsp_q       <= rsp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive, inhibit and trigger edges
  // pins stay released until the stored functions are in, so the reset
  // defaults never drive a pin that storage holds as input-only
  wire logic [6:0] oe_n_nxt = loading_q ? 7'h7f : ~drv_en; // next drive enables
  // no edges until synchroniser, polarity and history hold real levels
  wire logic       trig_arm = warm_q[2];                   // edge detect armed

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pin_o_q    <= 7'h00;
      pin_oe_n_q <= 7'h7f;
      inhibit_q  <= 1'b0;
      lvl_prev_q <= 7'h00;
      trig_q     <= 7'h00;
      warm_q     <= 3'h0;
    end else if (ce_in) begin
      pin_o_q    <= drv_lvl;
      pin_oe_n_q <= oe_n_nxt;
      inhibit_q  <= (cfg_q.func[SPDCP_INH_BIT] == SPDCP_FN_INHIBIT)
                    && lvl[SPDCP_INH_BIT];
      lvl_prev_q <= lvl;
      warm_q     <= {warm_q[1:0], 1'b1};
      trig_q     <= lvl & ~lvl_prev_q & ~drv_en & {7{trig_arm}};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign pin_o_out     = pin_o_q;
  assign pin_oe_n_out  = pin_oe_n_q;
  assign inhibit_out   = inhibit_q;
  assign trig_out      = trig_q;
  assign rsp_valid_out = rsp_valid_q;
  assign rsp_out       = rsp_q;
  assign nv_wr_out     = nv_wr_q;
  assign nv_cfg_out    = cfg_q;

endmodule

// ==== rtl/spdcp_pkg.sv ====
// constants, types and command layout of the seven-pin digital control port
// Function
// - input image: pins 1-7 in bits 0-6
// - output write changes only bidirectional pins
// - seven-bit output word, reset zero, pin n bit n-1
// - output bits of non-bidirectional pins ignored
// - bidirectional pin both drives and samples
// - input-only pin sampled, never driven
// - fault: pin 1 output, pin 2 return
// - inhibit: pin 3 is inhibit input
// - pin function kept in non-volatile storage
// - positive: high true, rising edge active
// - negative: low true, falling edge active
// - pin polarity kept in non-volatile storage
package spdcp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths and reset values
  localparam int unsigned SPDCP_PINS      = 7;     // signal pins on the port
  localparam int unsigned SPDCP_PIN_IDX_W = 3;     // pin number field, 1..7
  localparam logic [6:0]  SPDCP_OUT_RST   = 7'h00; // output word after reset
  localparam logic [6:0]  SPDCP_NEG_RST   = 7'h00; // all pins positive
  localparam logic [2:0]  SPDCP_FAULT_PIN = 3'h1;  // only pin allowed fault
  localparam logic [2:0]  SPDCP_INH_PIN   = 3'h3;  // only pin allowed inhibit
  localparam int unsigned SPDCP_FAULT_BIT = 0;     // bit index of pin 1
  localparam int unsigned SPDCP_RET_BIT   = 1;     // bit index of pin 2
  localparam int unsigned SPDCP_INH_BIT   = 2;     // bit index of pin 3

  ////////////////////////////////////////////////////////////////////////////
  // pin functions
  typedef enum logic [1:0] {
    SPDCP_FN_BIDIR,      // bidir_pin_function
    SPDCP_FN_INPUT_ONLY, // input_only_function
    SPDCP_FN_FAULT,      // isolated fault output, pin 1 only
    SPDCP_FN_INHIBIT     // inhibit input, pin 3 only
  } spdcp_func_t;

  // command opcodes
  typedef enum logic [2:0] {
    SPDCP_OP_WR_OUT,   // write port_output_value
    SPDCP_OP_RD_OUT,   // read port_output_value
    SPDCP_OP_RD_IN,    // read port_input_image
    SPDCP_OP_WR_FUNC,  // set one pin's function
    SPDCP_OP_RD_FUNC,  // read one pin's function
    SPDCP_OP_WR_POL,   // set one pin's polarity, data bit 0 = negative
    SPDCP_OP_RD_POL    // read one pin's polarity
  } spdcp_op_t;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    spdcp_op_t  op;   // what to do
    logic [2:0] pin;  // pin number 1..7 for function and polarity ops
    logic [6:0] data; // write value
  } spdcp_cmd_t;

  typedef struct packed {
    logic       err;  // command refused
    logic [6:0] data; // read value, zero for writes
  } spdcp_rsp_t;

  // configuration image held in non-volatile storage
  typedef struct packed {
    spdcp_func_t [6:0] func; // per-pin function, pin 1 at index 0
    logic [6:0]        neg;  // per-pin polarity, 1 = negative
  } spdcp_cfg_t;

  localparam spdcp_cfg_t SPDCP_CFG_RST = '{func: {7{SPDCP_FN_BIDIR}},
                                           neg:  SPDCP_NEG_RST};

endpackage

// ==== rtl/spdcp_sync.sv ====
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/10ps
module spdcp_sync #(
  parameter int unsigned WIDTH = 7 // number of levels
) (
  input  wire logic             clk_in,   // system clock
  input  wire logic             rst_n_in, // synchronous reset, low
  input  wire logic             ce_in,    // clock enable
  input  wire logic [WIDTH-1:0] async_in, // raw pin levels
  output logic      [WIDTH-1:0] sync_out  // synchronised levels
);

  logic [WIDTH-1:0] meta_q; // first stage, read only by second stage
  logic [WIDTH-1:0] sync_q; // second stage

  ////////////////////////////////////////////////////////////////////////////
  // two stages
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else if (ce_in) begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule

// ==== test/spdcp_asserts.sv ====
// assertion checker for the seven-pin digital control port
`timescale 1ns/10ps
module spdcp_asserts (
  input wire logic                  clk_in,        // system clock
  input wire logic                  rst_n_in,      // sync reset, low
  input wire logic                  ce_in,         // clock enable
  input wire logic                  cmd_valid_in,  // command offered
  input wire spdcp_pkg::spdcp_cmd_t cmd_in,        // command word
  input wire logic                  cmd_ready_out, // command accepted
  input wire logic                  rsp_valid_out, // answer pulse
  input wire spdcp_pkg::spdcp_rsp_t rsp_out,       // answer word
  input wire logic [6:0]            pin_o_out,     // drive levels
  input wire logic [6:0]            pin_oe_n_out,  // low while driving
  input wire logic                  fault_in,      // instrument fault
  input wire logic                  inhibit_out,   // inhibit asserted
  input wire logic [6:0]            trig_out,      // active-edge pulses
  input wire logic                  nv_wr_out,     // store pulse
  input wire spdcp_pkg::spdcp_cfg_t nv_cfg_out     // live configuration
);
  import spdcp_pkg::*;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  ////////////////////////////////////////////////////////////////////////////
  // per-pin function masks; pin 2 leaves general use under fault
  logic [6:0] bidir_w;
  logic [6:0] inonly_w;
  wire        taken_w = cmd_valid_in && cmd_ready_out && ce_in; // command taken
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      bidir_w[i]  = nv_cfg_out.func[i] == SPDCP_FN_BIDIR;
      inonly_w[i] = nv_cfg_out.func[i] == SPDCP_FN_INPUT_ONLY;
    end
    if (nv_cfg_out.func[0] == SPDCP_FN_FAULT) bidir_w[1] = 1'b0; // return pin
  end
  ////////////////////////////////////////////////////////////////////////////
  // command port
  property p_rsp_next; taken_w |=> rsp_valid_out; endproperty
  a_rsp_next: assert property (p_rsp_next) else $error("answer missing");
  property p_rsp_cause; rsp_valid_out |-> $past(taken_w); endproperty
  a_rsp_cause: assert property (p_rsp_cause) else $error("answer without command");
  property p_bad_op; taken_w && cmd_in.op == 3'h7 |=> rsp_out.err; endproperty
  a_bad_op: assert property (p_bad_op) else $error("illegal op accepted");
  // pin drive against the function held for two cycles
  property p_bidir; $past(cmd_ready_out) |-> (bidir_w & $past(bidir_w) & pin_oe_n_out) == 7'h00;
  endproperty
  a_bidir: assert property (p_bidir) else $error("bidir pin not driven");
  property p_inonly; $past(cmd_ready_out) |-> (inonly_w & $past(inonly_w) & ~pin_oe_n_out) == 0;
  endproperty
  a_inonly: assert property (p_inonly) else $error("input-only pin driven");
  property p_fault;
    $past(cmd_ready_out) && $past(nv_cfg_out.func[0]) == SPDCP_FN_FAULT
      |-> !pin_oe_n_out[0] && pin_oe_n_out[1] && pin_o_out[0] == $past(fault_in ^ nv_cfg_out.neg[0]);
  endproperty
  a_fault: assert property (p_fault) else $error("fault pin wrong");
  property p_inhibit;
    inhibit_out |-> $past(nv_cfg_out.func[2]) == SPDCP_FN_INHIBIT && pin_oe_n_out[2];
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("inhibit without function");
  // edge pulses only come from pins the port does not drive
  property p_trig; (trig_out & ~pin_oe_n_out) == 7'h00; endproperty
  a_trig: assert property (p_trig) else $error("edge pulse on driven pin");
  // every configuration change after the load from storage is stored, and only command writes store
  property p_nv_store; $past(cmd_ready_out) && !$stable(nv_cfg_out) |-> nv_wr_out; endproperty
  a_nv_store: assert property (p_nv_store) else $error("config change not stored");
  property p_nv_cause;
    nv_wr_out |-> $past(taken_w && cmd_in.op inside {SPDCP_OP_WR_FUNC, SPDCP_OP_WR_POL});
  endproperty
  a_nv_cause: assert property (p_nv_cause) else $error("store without write");
  c_wr_out: cover property (taken_w && cmd_in.op == SPDCP_OP_WR_OUT);
  c_store: cover property (nv_wr_out);
  c_inhibit: cover property (inhibit_out);
  c_trig: cover property (trig_out != 7'h00);
endmodule

// ==== test/spdcp_ext_model.sv ====
// far-side equipment wired to the rear digital port
`timescale 1ns/10ps
module spdcp_ext_model (
  input  wire logic [6:0] pin_o_in,    // device drive levels
  input  wire logic [6:0] pin_oe_n_in, // low while device drives
  input  wire logic [6:0] ext_drv_in,  // levels the equipment applies
  output logic      [6:0] pin_lvl_out  // resolved wire levels
);
  // a driven pin shows the device level, a released one the equipment's
  always_comb begin
    for (int i = 0; i < 7; i++) pin_lvl_out[i] = pin_oe_n_in[i] ? ext_drv_in[i] : pin_o_in[i];
  end
endmodule

// ==== test/seven_pin_digital_control_port_tb.sv ====
// self-checking testbench for the seven-pin digital control port
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module seven_pin_digital_control_port_tb;
  import spdcp_pkg::*;
  logic       clk_in = 1'b0, rst_n_in = 1'b0, cmd_valid_in = 1'b0, fault_in = 1'b0;
  logic       ce_in = 1'b1; // clock enable, low freezes the port
  logic       cmd_ready_out, rsp_valid_out, inhibit_out, nv_wr_out;
  logic [6:0] pin_o_out, pin_oe_n_out, pin_lvl_w, trig_out, ext_q = 7'h00;
  spdcp_cmd_t cmd_in = '0;
  spdcp_rsp_t rsp_out, rsp_q;
  spdcp_cfg_t nv_cfg_out, nv_q = SPDCP_CFG_RST; // non-volatile store
  int         num_errors = 0, n_compared = 0, cyc = 0;
  always #5 clk_in = ~clk_in;
  always @(posedge clk_in) if (nv_wr_out) nv_q <= nv_cfg_out;
  // hang guard
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      stop_test();
    end
  end
  spdcp_port i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
    .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in), .cmd_ready_out(cmd_ready_out),
    .rsp_valid_out(rsp_valid_out), .rsp_out(rsp_out), .pin_i_in(pin_lvl_w),
    .pin_o_out(pin_o_out), .pin_oe_n_out(pin_oe_n_out), .fault_in(fault_in),
    .inhibit_out(inhibit_out), .trig_out(trig_out), .nv_cfg_in(nv_q),
    .nv_wr_out(nv_wr_out), .nv_cfg_out(nv_cfg_out));
  spdcp_ext_model i_ext (.pin_o_in(pin_o_out), .pin_oe_n_in(pin_oe_n_out),
    .ext_drv_in(ext_q), .pin_lvl_out(pin_lvl_w));
  ////////////////////////////////////////////////////////////////////////////
  // one command, held until taken, answer kept in rsp_q
  task automatic cmd(input logic [2:0] op, input logic [2:0] pin, input logic [6:0] d);
    int n;
    n = 0;
    @(negedge clk_in);
    cmd_valid_in = 1'b1;
    cmd_in = '{op: spdcp_op_t'(op), pin: pin, data: d};
    while (cmd_ready_out !== 1'b1 && n < 20) begin
      @(negedge clk_in);
      n++;
    end
    @(negedge clk_in);
    `CHK(rsp_valid_out, 1'b1)
    rsp_q = rsp_out;
    cmd_valid_in = 1'b0;
  endtask
  task automatic ticks(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic do_reset;
    rst_n_in = 1'b0;
    ticks(12);
    `CHK(pin_oe_n_out, 7'h7f)
    rst_n_in = 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_output;
    cmd(SPDCP_OP_RD_OUT, 3'h0, 7'h00);
    `CHK(rsp_q.data, 7'h00)
    cmd(SPDCP_OP_WR_FUNC, 3'h4, 7'h01);
    cmd(SPDCP_OP_WR_OUT, 3'h0, 7'h7f);
    ticks(2);
    `CHK(pin_oe_n_out, 7'h08)
    `CHK(pin_o_out & 7'h77, 7'h77)
    cmd(SPDCP_OP_WR_OUT, 3'h0, 7'h40);
    ticks(2);
    `CHK(pin_o_out & 7'h77, 7'h40)
  endtask
  task automatic t_input;
    ext_q = 7'h08;
    cmd(SPDCP_OP_WR_POL, 3'h4, 7'h01);
    ticks(3);
    cmd(SPDCP_OP_RD_IN, 3'h0, 7'h00);
    `CHK(rsp_q.data, 7'h40)
    ext_q = 7'h00;
    ticks(3);
    `CHK(trig_out, 7'h08)
    cmd(SPDCP_OP_RD_IN, 3'h0, 7'h00);
    `CHK(rsp_q.data, 7'h48)
    cmd(SPDCP_OP_WR_POL, 3'h1, 7'h01);
    ticks(2);
    `CHK(pin_o_out[0], 1'b1)
  endtask
  task automatic t_fault;
    cmd(SPDCP_OP_WR_FUNC, 3'h2, 7'h02);
    `CHK(rsp_q.err, 1'b1)
    cmd(SPDCP_OP_WR_FUNC, 3'h1, 7'h02);
    fault_in = 1'b1;
    ticks(2);
    `CHK(pin_oe_n_out[1:0], 2'b10)
    `CHK(pin_o_out[0], 1'b0)
    fault_in = 1'b0;
    ticks(2);
    `CHK(pin_o_out[0], 1'b1)
  endtask
  task automatic t_inhibit;
    cmd(SPDCP_OP_WR_FUNC, 3'h5, 7'h03);
    `CHK(rsp_q.err, 1'b1)
    cmd(SPDCP_OP_WR_FUNC, 3'h3, 7'h03);
    ext_q = 7'h04;
    ticks(4);
    `CHK(inhibit_out, 1'b1)
    `CHK(trig_out, 7'h04)
    `CHK(pin_oe_n_out[2], 1'b1)
    cmd(3'h7, 3'h0, 7'h00);
    `CHK(rsp_q.err, 1'b1)
  endtask
  task automatic t_nonvol;
    do_reset();
    cmd(SPDCP_OP_RD_FUNC, 3'h1, 7'h00);
    `CHK(rsp_q.data[1:0], 2'h2)
    cmd(SPDCP_OP_RD_FUNC, 3'h4, 7'h00);
    `CHK(rsp_q.data[1:0], 2'h1)
    cmd(SPDCP_OP_RD_POL, 3'h4, 7'h00);
    `CHK(rsp_q.data[0], 1'b1)
    cmd(SPDCP_OP_RD_OUT, 3'h0, 7'h00);
    `CHK(rsp_q.data, 7'h00)
    cmd(SPDCP_OP_WR_FUNC, 3'h4, 7'h00);
    cmd(SPDCP_OP_RD_FUNC, 3'h4, 7'h00);
    `CHK(rsp_q.data[1:0], 2'h0)
    `CHK(pin_oe_n_out[3], 1'b0)
  endtask
  // clock enable low: an offered command waits, pins hold
  task automatic t_freeze;
    @(negedge clk_in);
    ce_in = 1'b0;
    cmd_valid_in = 1'b1;
    cmd_in = '{op: SPDCP_OP_WR_OUT, pin: 3'h0, data: 7'h7f};
    ticks(3);
    `CHK(rsp_valid_out, 1'b0)
    `CHK(pin_o_out & 7'h70, 7'h00)
    ce_in = 1'b1;
    @(negedge clk_in);
    `CHK(rsp_valid_out, 1'b1)
    cmd_valid_in = 1'b0;
    ticks(2);
    `CHK(pin_o_out & 7'h70, 7'h70)
  endtask
  task automatic stop_test;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    do_reset();
    t_output();
    t_input();
    t_fault();
    t_inhibit();
    t_nonvol();
    t_freeze();
    stop_test();
  end
endmodule
bind spdcp_port spdcp_asserts i_chk (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
  .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in), .cmd_ready_out(cmd_ready_out),
  .rsp_valid_out(rsp_valid_out), .rsp_out(rsp_out), .pin_o_out(pin_o_out),
  .pin_oe_n_out(pin_oe_n_out), .fault_in(fault_in), .inhibit_out(inhibit_out),
  .trig_out(trig_out), .nv_wr_out(nv_wr_out), .nv_cfg_out(nv_cfg_out));
